// ### shared/ipr_pkg.sv
// constants and carrier types for the interrupt priority register bank
package ipr_pkg;

	// ------------------------------------------------------------
	// bus and register geometry
	// ------------------------------------------------------------
	localparam int IPR_DATA_W = 16;
	localparam int IPR_ADDR_W = 2;
	localparam int IPR_PRIO_W = 3;
	localparam int IPR_NSRC   = 5;
	localparam int IPR_SRC_W  = 3;

	localparam logic [IPR_ADDR_W-1:0] IPR_OFS_CN   = 2'h0;
	localparam logic [IPR_ADDR_W-1:0] IPR_OFS_CMPA = 2'h1;
	localparam logic [IPR_ADDR_W-1:0] IPR_OFS_CMPB = 2'h2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int IPR_CN_LSB   = 12;
	localparam int IPR_CMP3_LSB = 12;
	localparam int IPR_CMP2_LSB = 8;
	localparam int IPR_CMP1_LSB = 4;
	localparam int IPR_CMP4_LSB = 0;

	// implemented bits per register; everything else reads zero
	localparam logic [IPR_DATA_W-1:0] IPR_MASK_CN   = 16'h7000;
	localparam logic [IPR_DATA_W-1:0] IPR_MASK_CMPA = 16'h7770;
	localparam logic [IPR_DATA_W-1:0] IPR_MASK_CMPB = 16'h0007;

	// ------------------------------------------------------------
	// priority codes and reset value
	// ------------------------------------------------------------
	localparam logic [IPR_PRIO_W-1:0] IPR_PRIO_OFF = 3'h0;
	localparam logic [IPR_PRIO_W-1:0] IPR_PRIO_MIN = 3'h1;
	localparam logic [IPR_PRIO_W-1:0] IPR_PRIO_MAX = 3'h7;
	localparam logic [IPR_PRIO_W-1:0] IPR_PRIO_RST = 3'h4;

	// ------------------------------------------------------------
	// source indices
	// ------------------------------------------------------------
	localparam int IPR_SRC_CN   = 0;
	localparam int IPR_SRC_CMP1 = 1;
	localparam int IPR_SRC_CMP2 = 2;
	localparam int IPR_SRC_CMP3 = 3;
	localparam int IPR_SRC_CMP4 = 4;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [IPR_ADDR_W-1:0] addr;
		logic [IPR_DATA_W-1:0] wdata;
	} ipr_bus_t;

	typedef struct packed {
		logic [IPR_PRIO_W-1:0] cmp4;
		logic [IPR_PRIO_W-1:0] cmp3;
		logic [IPR_PRIO_W-1:0] cmp2;
		logic [IPR_PRIO_W-1:0] cmp1;
		logic [IPR_PRIO_W-1:0] cn;
	} ipr_levels_t;

endpackage

// ### core/ipr_prio_field.sv
// one writable 3-bit priority field with its reset value
`timescale 1ns/100ps
module ipr_prio_field #(
	parameter logic [ipr_pkg::IPR_PRIO_W-1:0] RST_VAL = ipr_pkg::IPR_PRIO_RST
) (
	input  wire logic                             clk_sys,
	input  wire logic                             reset,
	input  wire logic                             wr_en,
	input  wire logic [ipr_pkg::IPR_PRIO_W-1:0]   wr_val,
	output logic      [ipr_pkg::IPR_PRIO_W-1:0]   val_r
);
	import ipr_pkg::*;

	logic [IPR_PRIO_W-1:0] val_nxt;

	always_comb begin
		val_nxt = val_r;
		if (wr_en) begin
			val_nxt = wr_val;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			val_r <= RST_VAL;
		end else begin
			val_r <= val_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	field_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		!wr_en |=> val_r == $past(val_r))
		else $error("priority field changed without a write");

	field_load_a: assert property (@(posedge clk_sys) disable iff (reset)
		wr_en |=> val_r == $past(wr_val))
		else $error("priority field missed its write");

endmodule

// ### core/ipr_prio_regs.sv
// priority register bank for change notification and four comparators
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ipr_prio_regs #(
	parameter int NSRC = ipr_pkg::IPR_NSRC
) (
	input  wire logic                            clk_sys,
	input  wire logic                            reset,
	input  wire ipr_pkg::ipr_bus_t               bus,
	output logic      [ipr_pkg::IPR_DATA_W-1:0]  rd_data_r,
	input  wire logic [NSRC-1:0]                 src_req,
	output ipr_pkg::ipr_levels_t                 prio_levels,
	output logic      [NSRC-1:0]                 req_live_r,
	output logic                                 win_valid_r,
	output logic      [ipr_pkg::IPR_SRC_W-1:0]   win_src_r,
	output logic      [ipr_pkg::IPR_PRIO_W-1:0]  win_level_r
);
	import ipr_pkg::*;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	logic wr_cn;
	logic wr_cmpa;
	logic wr_cmpb;

	assign wr_cn   = bus.wr && (bus.addr == IPR_OFS_CN);
	assign wr_cmpa = bus.wr && (bus.addr == IPR_OFS_CMPA);
	assign wr_cmpb = bus.wr && (bus.addr == IPR_OFS_CMPB);

	// ------------------------------------------------------------
	// priority fields
	// ------------------------------------------------------------
	// writes to unimplemented bits simply have no flop to land in
	logic [IPR_PRIO_W-1:0] pin_change_prio;
	logic [IPR_PRIO_W-1:0] cmp1_prio;
	logic [IPR_PRIO_W-1:0] cmp2_prio;
	logic [IPR_PRIO_W-1:0] cmp3_prio;
	logic [IPR_PRIO_W-1:0] cmp4_prio;

	ipr_prio_field u_cn (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_cn),
		.wr_val  (bus.wdata[IPR_CN_LSB +: IPR_PRIO_W]),
		.val_r   (pin_change_prio)
	);

	ipr_prio_field u_cmp3 (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_cmpa),
		.wr_val  (bus.wdata[IPR_CMP3_LSB +: IPR_PRIO_W]),
		.val_r   (cmp3_prio)
	);

	ipr_prio_field u_cmp2 (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_cmpa),
		.wr_val  (bus.wdata[IPR_CMP2_LSB +: IPR_PRIO_W]),
		.val_r   (cmp2_prio)
	);

	ipr_prio_field u_cmp1 (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_cmpa),
		.wr_val  (bus.wdata[IPR_CMP1_LSB +: IPR_PRIO_W]),
		.val_r   (cmp1_prio)
	);

	ipr_prio_field u_cmp4 (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_cmpb),
		.wr_val  (bus.wdata[IPR_CMP4_LSB +: IPR_PRIO_W]),
		.val_r   (cmp4_prio)
	);

	assign prio_levels.cn   = pin_change_prio;
	assign prio_levels.cmp1 = cmp1_prio;
	assign prio_levels.cmp2 = cmp2_prio;
	assign prio_levels.cmp3 = cmp3_prio;
	assign prio_levels.cmp4 = cmp4_prio;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// data only in the cycle after the strobe, zero otherwise
	logic [IPR_DATA_W-1:0] rd_data_nxt;
	logic [IPR_DATA_W-1:0] img_cn;
	logic [IPR_DATA_W-1:0] img_cmpa;
	logic [IPR_DATA_W-1:0] img_cmpb;

	always_comb begin
		img_cn = '0;
		img_cn[IPR_CN_LSB +: IPR_PRIO_W] = pin_change_prio;
		img_cmpa = '0;
		img_cmpa[IPR_CMP3_LSB +: IPR_PRIO_W] = cmp3_prio;
		img_cmpa[IPR_CMP2_LSB +: IPR_PRIO_W] = cmp2_prio;
		img_cmpa[IPR_CMP1_LSB +: IPR_PRIO_W] = cmp1_prio;
		img_cmpb = '0;
		img_cmpb[IPR_CMP4_LSB +: IPR_PRIO_W] = cmp4_prio;
	end

	always_comb begin
		rd_data_nxt = '0;
		if (bus.rd) begin
			case (bus.addr)
				IPR_OFS_CN: begin
					rd_data_nxt = img_cn & IPR_MASK_CN;
				end
				IPR_OFS_CMPA: begin
					rd_data_nxt = img_cmpa & IPR_MASK_CMPA;
				end
				IPR_OFS_CMPB: begin
					rd_data_nxt = img_cmpb & IPR_MASK_CMPB;
				end
				default: begin
					rd_data_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// ------------------------------------------------------------
	// source gating and highest-level pick
	// ------------------------------------------------------------
	// ties go to the lowest source index; no vectoring beyond that
	logic [IPR_PRIO_W-1:0] lvl [NSRC];
	logic [NSRC-1:0]       live_nxt;
	logic                  win_valid_nxt;
	logic [IPR_SRC_W-1:0]  win_src_nxt;
	logic [IPR_PRIO_W-1:0] win_level_nxt;

	assign lvl[IPR_SRC_CN]   = pin_change_prio;
	assign lvl[IPR_SRC_CMP1] = cmp1_prio;
	assign lvl[IPR_SRC_CMP2] = cmp2_prio;
	assign lvl[IPR_SRC_CMP3] = cmp3_prio;
	assign lvl[IPR_SRC_CMP4] = cmp4_prio;

	always_comb begin
		live_nxt      = '0;
		win_valid_nxt = 1'b0;
		win_src_nxt   = '0;
		win_level_nxt = IPR_PRIO_OFF;
		for (int i = 0; i < NSRC; i++) begin
			live_nxt[i] = src_req[i] && (lvl[i] != IPR_PRIO_OFF);
			if (live_nxt[i] && (lvl[i] > win_level_nxt)) begin
				win_valid_nxt = 1'b1;
				win_src_nxt   = IPR_SRC_W'(i);
				win_level_nxt = lvl[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			req_live_r  <= '0;
			win_valid_r <= 1'b0;
			win_src_r   <= '0;
			win_level_r <= IPR_PRIO_OFF;
		end else begin
			req_live_r  <= live_nxt;
			win_valid_r <= win_valid_nxt;
			win_src_r   <= win_src_nxt;
			win_level_r <= win_level_nxt;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence wr_then_rd(logic [IPR_ADDR_W-1:0] a);
		bus.wr && bus.addr == a ##1 bus.rd && bus.addr == a;
	endsequence

	rd_idle_zero_a: assert property (!bus.rd |=> rd_data_r == '0)
		else $error("read data not zero outside a read");

	cn_unimpl_a: assert property (
		bus.rd && bus.addr == IPR_OFS_CN |=>
		(rd_data_r & ~IPR_MASK_CN) == '0 &&
		rd_data_r[IPR_CN_LSB +: IPR_PRIO_W] == pin_change_prio)
		else $error("change notify register read wrong");

	cmpa_bits_a: assert property (
		bus.rd && bus.addr == IPR_OFS_CMPA |=>
		rd_data_r[15] == 1'b0 && rd_data_r[11] == 1'b0 &&
		rd_data_r[7] == 1'b0 && rd_data_r[3:0] == 4'h0)
		else $error("unimplemented comparator a bit read as one");

	cmpb_unimpl_a: assert property (
		bus.rd && bus.addr == IPR_OFS_CMPB |=>
		rd_data_r[15:3] == 13'h0)
		else $error("unimplemented comparator b bit read as one");

	// address 3 decodes to nothing: no field, no data
	unmapped_rd_a: assert property (
		bus.rd && bus.addr == 2'h3 |=> rd_data_r == '0)
		else $error("unmapped register read not zero");

	unmapped_wr_a: assert property (
		bus.wr && bus.addr == 2'h3 |=> $stable(prio_levels))
		else $error("unmapped register write moved a field");

	cn_map_a: assert property (
		wr_then_rd(IPR_OFS_CN) |=>
		rd_data_r == {1'b0, $past(bus.wdata[14:12], 2), 12'h000})
		else $error("change notify field misplaced");

	cmp3_map_a: assert property (
		wr_then_rd(IPR_OFS_CMPA) |=>
		rd_data_r[14:12] == $past(bus.wdata[14:12], 2) &&
		rd_data_r[10:8] == $past(bus.wdata[10:8], 2))
		else $error("cmp3 or cmp2 field misplaced");

	cmp1_map_a: assert property (
		wr_then_rd(IPR_OFS_CMPA) |=>
		rd_data_r[6:4] == $past(bus.wdata[6:4], 2))
		else $error("cmp1 field misplaced");

	cmp4_map_a: assert property (
		wr_then_rd(IPR_OFS_CMPB) |=>
		rd_data_r == {13'h0, $past(bus.wdata[2:0], 2)})
		else $error("comparator b read not just cmp4 field");

	reset_level_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset |=> pin_change_prio == IPR_PRIO_RST &&
		cmp1_prio == IPR_PRIO_RST && cmp2_prio == IPR_PRIO_RST &&
		cmp3_prio == IPR_PRIO_RST && cmp4_prio == IPR_PRIO_RST)
		else $error("priority field not at level four after reset");

	off_blocks_a: assert property (
		src_req[IPR_SRC_CMP1] && cmp1_prio == IPR_PRIO_OFF |=>
		!req_live_r[IPR_SRC_CMP1] &&
		!(win_valid_r && win_src_r == IPR_SRC_W'(IPR_SRC_CMP1)))
		else $error("disabled source was taken");

	top_wins_a: assert property (
		src_req[IPR_SRC_CMP4] && cmp4_prio == IPR_PRIO_MAX &&
		pin_change_prio != IPR_PRIO_MAX |=>
		win_valid_r && win_level_r == IPR_PRIO_MAX &&
		win_src_r != IPR_SRC_W'(IPR_SRC_CN))
		else $error("level seven request did not win");

	lowest_lvl_a: assert property (
		src_req == 5'h01 && pin_change_prio == IPR_PRIO_MIN |=>
		win_valid_r && win_level_r == IPR_PRIO_MIN &&
		win_src_r == IPR_SRC_W'(IPR_SRC_CN))
		else $error("level one request not taken at level one");

	win_nonzero_a: assert property (
		win_valid_r |-> win_level_r != IPR_PRIO_OFF && req_live_r != '0)
		else $error("winner without a live enabled request");

	cmp4_live_a: assert property (
		src_req[IPR_SRC_CMP4] && cmp4_prio != IPR_PRIO_OFF |=>
		req_live_r[IPR_SRC_CMP4] && win_valid_r)
		else $error("enabled request not taken");

	tie_low_a: assert property (
		src_req[IPR_SRC_CN] && src_req[IPR_SRC_CMP1] &&
		pin_change_prio == cmp1_prio && cmp1_prio != IPR_PRIO_OFF |=>
		win_src_r != IPR_SRC_W'(IPR_SRC_CMP1))
		else $error("tie not resolved to the lower source");

	// every live source ranks no higher than the winner
	for (genvar g = 0; g < NSRC; g++) begin : g_rank
		rank_order_a: assert property (@(posedge clk_sys) disable iff (reset)
			req_live_r[g] |-> win_valid_r && win_level_r >= $past(lvl[g]))
			else $error("live source outranks the winner");
	end

	wr_cmpb_c: cover property (wr_then_rd(IPR_OFS_CMPB));
	wr_cmpa_c: cover property (wr_then_rd(IPR_OFS_CMPA));
	max_win_c: cover property (win_valid_r && win_level_r == IPR_PRIO_MAX);
	low_win_c: cover property (win_valid_r && win_level_r == IPR_PRIO_MIN);
	off_req_c: cover property (src_req[IPR_SRC_CN] && pin_change_prio == IPR_PRIO_OFF);

endmodule

// ### verification/test_ipr_prio_regs.sv
// self-checking bench for the interrupt priority register bank
`timescale 1ns/100ps
module test_ipr_prio_regs;
	import ipr_pkg::*;

	logic                    clk_sys   = 1'b0;
	logic                    reset     = 1'b1;
	ipr_bus_t                bus       = '0;
	logic [IPR_NSRC-1:0]     src_req   = 5'h00;
	logic [IPR_DATA_W-1:0]   rd_data_r;
	ipr_levels_t             prio_levels;
	logic [IPR_NSRC-1:0]     req_live_r;
	logic                    win_valid_r;
	logic [IPR_SRC_W-1:0]    win_src_r;
	logic [IPR_PRIO_W-1:0]   win_level_r;
	logic [IPR_DATA_W-1:0]   model [4];
	logic [IPR_DATA_W-1:0]   rd_q [$];
	logic [11:0]             win_q [$];
	logic                    rd_pend   = 1'b0;
	logic                    win_pend  = 1'b0;
	logic                    chk_win   = 1'b0;
	int                      fails     = 0;
	int                      cmp_count = 0;
	int                      cycles    = 0;
	int                      seed      = 18144;

	ipr_prio_regs ipr_prio_regs_i (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.bus         (bus),
		.rd_data_r   (rd_data_r),
		.src_req     (src_req),
		.prio_levels (prio_levels),
		.req_live_r  (req_live_r),
		.win_valid_r (win_valid_r),
		.win_src_r   (win_src_r),
		.win_level_r (win_level_r)
	);

	always #20 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// reference model and helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] mask(input logic [1:0] a);
		case (a)
			IPR_OFS_CN:   return IPR_MASK_CN;
			IPR_OFS_CMPA: return IPR_MASK_CMPA;
			IPR_OFS_CMPB: return IPR_MASK_CMPB;
			default:      return 16'h0000;
		endcase
	endfunction

	task automatic reset_model();
		model[0] = 16'h4000;
		model[1] = 16'h4440;
		model[2] = 16'h0004;
		model[3] = 16'h0000;
	endtask

	// strict greater keeps the lowest index on a tie
	function automatic logic [11:0] expect_win(input logic [4:0] r);
		logic [2:0] lvl [5];
		logic [4:0] live;
		logic [2:0] bs;
		logic [2:0] bl;
		lvl[0] = model[0][14:12];
		lvl[1] = model[1][6:4];
		lvl[2] = model[1][10:8];
		lvl[3] = model[1][14:12];
		lvl[4] = model[2][2:0];
		live = 5'h00;
		bs = 3'h0;
		bl = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (r[i] && lvl[i] != 3'h0) begin
				live[i] = 1'b1;
				if (lvl[i] > bl) begin
					bl = lvl[i];
					bs = 3'(i);
				end
			end
		end
		return {live, |live, bs, bl};
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// bus and request drivers
	// ------------------------------------------------------------
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		chk_win <= 1'b0;
		model[a] = d & mask(a);
	endtask

	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		chk_win <= 1'b0;
		rd_q.push_back(model[a]);
	endtask

	task automatic req(input logic [4:0] r);
		@(posedge clk_sys);
		bus <= '0;
		src_req <= r;
		chk_win <= 1'b1;
		win_q.push_back(expect_win(r));
	endtask

	// lets the last strobe land before the field outputs are sampled
	task automatic idle_check();
		@(posedge clk_sys);
		bus <= '0;
		chk_win <= 1'b0;
		@(negedge clk_sys);
		check("prio_levels", {1'b0, model[2][2:0], model[1][14:12], model[1][10:8],
			model[1][6:4], model[0][14:12]}, {1'b0, prio_levels});
	endtask

	// ------------------------------------------------------------
	// output monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rd_pend)
			check("rd_data_r", rd_q.pop_front(), rd_data_r);
		else if (!reset)
			check("rd_data_r idle", 16'h0000, rd_data_r);
		if (win_pend)
			check("winner", {4'h0, win_q.pop_front()},
				{4'h0, req_live_r, win_valid_r, win_src_r, win_level_r});
		rd_pend  <= bus.rd & ~reset;
		win_pend <= chk_win & ~reset;
		cycles++;
		if (cycles > 5000) begin
			fails++;
			$display("[FAIL] run cycles expected 5000 seen %0d", cycles);
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset_model();
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		for (int a = 0; a < 4; a++)
			rd(2'(a));
		idle_check();
		$display("test reset_values done");
		for (int a = 0; a < 4; a++) begin
			wr(2'(a), 16'hFFFF);
			rd(2'(a));
		end
		idle_check();
		for (int a = 0; a < 4; a++) begin
			wr(2'(a), 16'h0000);
			rd(2'(a));
		end
		req(5'h1F);
		idle_check();
		$display("test field_map done");
		wr(IPR_OFS_CMPB, 16'h0007);
		for (int k = 0; k < 8; k++) begin
			wr(IPR_OFS_CN, {1'b0, 3'(k), 12'h000});
			wr(IPR_OFS_CMPA, 16'h0010);
			req(5'h03);
			req(5'h02);
			req(5'h11);
			req(5'h01);
		end
		$display("test priority_codes done");
		repeat (60) begin
			wr(2'($unsigned($random(seed)) % 3), 16'($random(seed)));
			req(5'($random(seed)));
			rd(2'($unsigned($random(seed)) % 4));
		end
		idle_check();
		$display("test random_traffic done");
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		reset_model();
		for (int a = 0; a < 3; a++)
			rd(2'(a));
		req(5'h1F);
		idle_check();
		$display("test mid_run_reset done");
		repeat (3) @(posedge clk_sys);
		give_verdict();
	end
endmodule
